// ===== rtl/txqm_pkg.sv
// txqm_pkg: register map, field positions, reset values and types
// shared by the transmit queue manager and its packet ram
package txqm_pkg;
  // buffer geometry: one slot per packet number
  localparam int PKT_W = 3;
  localparam int NPKT = 8;
  localparam int WORD_W = 6;
  localparam int RAM_AW = PKT_W + WORD_W;
  localparam int RAM_WORDS = 512;
  localparam logic [15:0] SLOT_BYTES = 16'h0100;
  localparam int AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_ALLOC = 8'h08;
  localparam logic [7:0] ADR_PKTNUM = 8'h0c;
  localparam logic [7:0] ADR_PTR = 8'h10;
  localparam logic [7:0] ADR_DATA = 8'h14;
  localparam logic [7:0] ADR_INTSTAT = 8'h18;
  localparam logic [7:0] ADR_INTMASK = 8'h1c;
  localparam logic [7:0] ADR_PORTS = 8'h20;
  localparam logic [7:0] ADR_TXACK = 8'h24;
  localparam logic [7:0] ADR_TXSTAT = 8'h28;
  // transmit_control_reg bits
  localparam int CTRL_TXEN = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_HALF = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // command opcodes in bits 3:0, byte count in bits 31:16
  localparam logic [3:0] CMD_ALLOC = 4'h1;
  localparam logic [3:0] CMD_RELEASE = 4'h2;
  localparam logic [3:0] CMD_ENQUEUE = 4'h3;
  localparam int CMD_SIZE_LSB = 16;
  // interrupt status and mask bits
  localparam int INT_ALLOC = 0;
  localparam int INT_TX = 1;
  localparam int INT_DRAIN = 2;
  localparam logic [2:0] MASK_RST = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register read sequencer
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_MEM = 2'b01,
    RD_GRAB = 2'b10,
    RD_RESP = 2'b11
  } txqm_rd_t;
endpackage : txqm_pkg

// ===== rtl/txqm_ram_if.sv
// txqm_ram_if: single port of the packet ram
// assumes one owner drives it and the ram answers one cycle later
`timescale 1ns/10ps
interface txqm_ram_if;
  logic ce;
  logic we;
  logic [txqm_pkg::RAM_AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport owner (output ce, output we, output addr, output wdata, input rdata);
  modport ram (input ce, input we, input addr, input wdata, output rdata);
endinterface : txqm_ram_if

// ===== rtl/txqm_pkt_ram.sv
// txqm_pkt_ram: packet buffer words, one port, registered read data
// assumes the owner never needs a read in the cycle it writes
`timescale 1ns/10ps
module txqm_pkt_ram
(
  // clock
  input wire logic clock,
  // owner port
  txqm_ram_if.ram bus
);
  import txqm_pkg::*;

  logic [31:0] mem [RAM_WORDS];
  logic [31:0] rdata_ff;

  assign bus.rdata = rdata_ff;

  // no reset on the array: contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (bus.ce)
    begin
      if (bus.we)
        mem[bus.addr] <= bus.wdata;
      rdata_ff <= mem[bus.addr];
    end
  end
endmodule : txqm_pkt_ram

// ===== rtl/txqm_core.sv
// txqm_core: transmit packet queue manager with an axi4-lite register slave
// assumes a mac transmit engine on the same clock and a single bus master
// Functional notes
// - an allocate command reserves a buffer slot for the given byte count
// - a granted allocation sets the done flag and posts the packet number
// - enqueue pushes the packet number register into the transmit fifo
// - hand-off to the mac needs tx enable and, half duplex, no deferral
// - on completion the status word overwrites word zero of the buffer
// - on completion the number leaves the transmit fifo and, unless auto released, enters the completion fifo
// - transmit interrupt stands while the completion fifo is not empty
// - a failed packet clears tx enable and halts the queue
// - the failed packet number shows on the transmit side of ports
// - after the number is written back, status reads through data
// - without auto release, a release command returns the slot
// - a write to the acknowledge register pops the completion fifo
// - auto release frees slots itself and flags a drained queue
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module txqm_core
(
  // clock, reset and freeze
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write channels
  input wire logic [txqm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [txqm_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mac transmit engine
  output logic macTxValid,
  output logic [txqm_pkg::PKT_W-1:0] macTxPkt,
  input wire logic macTxReady,
  input wire logic macDeferBusy,
  input wire logic macDone,
  input wire logic macOk,
  input wire logic [31:0] macStatus,
  // interrupt
  output logic irq
);
  import txqm_pkg::*;

  txqm_ram_if ramBus ();

  txqm_pkt_ram uRam (
    .clock(clock),
    .bus(ramBus)
  );

  // lowest free slot; msb set means none is free
  function automatic logic [PKT_W:0] firstFree(input logic [NPKT-1:0] used);
    logic [PKT_W:0] r;
    r = {1'b1, {PKT_W{1'b0}}};
    for (int i = NPKT - 1; i >= 0; i--)
    begin
      if (!used[i])
        r = {1'b0, PKT_W'(i)};
    end
    return r;
  endfunction : firstFree

  function automatic logic regHit(input logic [AXI_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= ADR_TXSTAT);
  endfunction : regHit

  // write channel holding registers
  logic awHeld_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic wHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  // host visible state
  logic [2:0] ctrl_ff;
  logic [2:0] intMask_ff;
  logic intAlloc_ff;
  logic intDrain_ff;
  logic [PKT_W-1:0] pktNum_ff;
  logic [WORD_W-1:0] ptr_ff;
  logic [31:0] txStat_ff;
  logic irq_ff;
  // buffer_memory_manager
  logic [NPKT-1:0] used_ff;
  logic allocPend_ff;
  logic [15:0] allocSize_ff;
  logic allocValid_ff;
  logic [PKT_W-1:0] allocRes_ff;
  // transmit and completion fifos
  logic [PKT_W-1:0] txq_ff [NPKT];
  logic [PKT_W:0] txWr_ff;
  logic [PKT_W:0] txRd_ff;
  logic [PKT_W-1:0] cplq_ff [NPKT];
  logic [PKT_W:0] cplWr_ff;
  logic [PKT_W:0] cplRd_ff;
  logic inFlight_ff;
  logic [PKT_W-1:0] flightPkt_ff;
  logic failFlag_ff;
  logic [PKT_W-1:0] failPkt_ff;
  // read side
  txqm_rd_t rdState_ff;
  logic [AXI_AW-1:0] arAddr_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic rvalid_ff;
  logic [31:0] rdMux;

  logic wrGo;
  logic wrEn;
  logic cmdGo;
  logic allocCmd;
  logic relGo;
  logic enqGo;
  logic ackGo;
  logic dataWr;
  logic rdAdv;
  logic [PKT_W:0] freeInfo;
  logic allocOk;
  logic [PKT_W:0] txCount;
  logic [PKT_W:0] cplCount;
  logic tx_queue_drained_flag;
  logic txFull;
  logic cplEmpty;
  logic cplFull;
  logic txPush;
  logic txPop;
  logic autoFree;
  logic cplPush;
  logic cplPop;
  logic [2:0] intStat;
  logic [PKT_W-1:0] txWrIdx;

  // a data write waits out a status write, the ram has one port
  assign wrGo = awHeld_ff && wHeld_ff && !bvalid_ff && !((awAddr_ff == ADR_DATA) && macDone);
  assign wrEn = wrGo && regHit(awAddr_ff) && (wStrb_ff != 4'h0);
  assign cmdGo = wrEn && (awAddr_ff == ADR_CMD);
  assign allocCmd = cmdGo && (wData_ff[3:0] == CMD_ALLOC);
  assign relGo = cmdGo && (wData_ff[3:0] == CMD_RELEASE);
  assign enqGo = cmdGo && (wData_ff[3:0] == CMD_ENQUEUE);
  assign ackGo = wrEn && (awAddr_ff == ADR_TXACK);
  assign dataWr = wrEn && (awAddr_ff == ADR_DATA);
  assign rdAdv = (rdState_ff == RD_MEM) && !ramBus.we && (arAddr_ff == ADR_DATA);

  assign s_axi_awready = !awHeld_ff;
  assign s_axi_wready = !wHeld_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // address and data are caught independently, the response follows both
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !awHeld_ff)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      else if (wrGo)
        awHeld_ff <= 1'b0;
      if (s_axi_wvalid && !wHeld_ff)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      else if (wrGo)
        wHeld_ff <= 1'b0;
      if (wrGo)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= regHit(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // control, mask, packet number and pointer registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_ff <= CTRL_RST;
      intMask_ff <= MASK_RST;
      pktNum_ff <= '0;
      ptr_ff <= '0;
    end
    else if (ce)
    begin
      if (wrEn && (awAddr_ff == ADR_CTRL))
        ctrl_ff <= wData_ff[2:0];
      // hardware clear is placed last so a failure beats a racing write
      if (txPop && !macOk)
        ctrl_ff[CTRL_TXEN] <= 1'b0;
      if (wrEn && (awAddr_ff == ADR_INTMASK))
        intMask_ff <= wData_ff[2:0];
      if (wrEn && (awAddr_ff == ADR_PKTNUM))
        pktNum_ff <= wData_ff[PKT_W-1:0];
      if (wrEn && (awAddr_ff == ADR_PTR))
        ptr_ff <= wData_ff[WORD_W-1:0];
      else if (dataWr || rdAdv)
        ptr_ff <= ptr_ff + WORD_W'(1);
    end
  end

  assign freeInfo = firstFree(used_ff);
  // an oversize request never fits a slot and simply stays pending
  assign allocOk = allocPend_ff && !freeInfo[PKT_W] && (allocSize_ff <= SLOT_BYTES) && !allocCmd;
  assign autoFree = txPop && ctrl_ff[CTRL_AUTO] && macOk;

  // slot allocation and release
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      used_ff <= '0;
      allocPend_ff <= 1'b0;
      allocSize_ff <= 16'h0;
      allocValid_ff <= 1'b0;
      allocRes_ff <= '0;
    end
    else if (ce)
    begin
      if (allocCmd)
      begin
        allocPend_ff <= 1'b1;
        allocSize_ff <= wData_ff[CMD_SIZE_LSB +: 16];
        allocValid_ff <= 1'b0;
      end
      else if (allocOk)
      begin
        allocPend_ff <= 1'b0;
        allocValid_ff <= 1'b1;
        allocRes_ff <= freeInfo[PKT_W-1:0];
      end
      if (relGo)
        used_ff[pktNum_ff] <= 1'b0;
      if (autoFree)
        used_ff[flightPkt_ff] <= 1'b0;
      if (allocOk)
        used_ff[freeInfo[PKT_W-1:0]] <= 1'b1;
    end
  end

  assign txCount = txWr_ff - txRd_ff;
  assign cplCount = cplWr_ff - cplRd_ff;
  assign tx_queue_drained_flag = (txCount == '0);
  assign txFull = txCount[PKT_W];
  assign cplEmpty = (cplCount == '0);
  assign cplFull = cplCount[PKT_W];
  assign txWrIdx = txWr_ff[PKT_W-1:0];
  assign txPush = enqGo && !txFull;
  assign txPop = macDone && inFlight_ff;
  assign cplPush = txPop && !autoFree && !cplFull;
  assign cplPop = ackGo && !cplEmpty;

  // the head stays queued while the mac sends it, so a halt keeps order
  assign macTxValid = !tx_queue_drained_flag && !inFlight_ff && ctrl_ff[CTRL_TXEN]
                      && !(ctrl_ff[CTRL_HALF] && macDeferBusy);
  assign macTxPkt = txq_ff[txRd_ff[PKT_W-1:0]];

  // transmit fifo and mac hand-off
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      txWr_ff <= '0;
      txRd_ff <= '0;
      inFlight_ff <= 1'b0;
      flightPkt_ff <= '0;
      failFlag_ff <= 1'b0;
      failPkt_ff <= '0;
      txStat_ff <= 32'h0;
    end
    else if (ce)
    begin
      if (txPush)
      begin
        txq_ff[txWrIdx] <= pktNum_ff;
        txWr_ff <= txWr_ff + (PKT_W + 1)'(1);
      end
      if (macTxValid && macTxReady)
      begin
        inFlight_ff <= 1'b1;
        flightPkt_ff <= macTxPkt;
      end
      else if (txPop)
        inFlight_ff <= 1'b0;
      if (txPop)
      begin
        txRd_ff <= txRd_ff + (PKT_W + 1)'(1);
        txStat_ff <= macStatus;
      end
      if (wrEn && (awAddr_ff == ADR_CTRL) && wData_ff[CTRL_TXEN])
        failFlag_ff <= 1'b0;
      if (txPop && !macOk)
      begin
        failFlag_ff <= 1'b1;
        failPkt_ff <= flightPkt_ff;
      end
    end
  end

  // completion fifo, drained by acknowledge writes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cplWr_ff <= '0;
      cplRd_ff <= '0;
    end
    else if (ce)
    begin
      if (cplPush)
      begin
        cplq_ff[cplWr_ff[PKT_W-1:0]] <= flightPkt_ff;
        cplWr_ff <= cplWr_ff + (PKT_W + 1)'(1);
      end
      if (cplPop)
        cplRd_ff <= cplRd_ff + (PKT_W + 1)'(1);
    end
  end

  // status word lands in word zero; host data words take the other cycles
  always_comb
  begin
    ramBus.we = 1'b0;
    ramBus.addr = {pktNum_ff, ptr_ff};
    ramBus.wdata = wData_ff;
    if (txPop)
    begin
      ramBus.we = 1'b1;
      ramBus.addr = {flightPkt_ff, {WORD_W{1'b0}}};
      ramBus.wdata = macStatus;
    end
    else if (dataWr)
      ramBus.we = 1'b1;
  end
  assign ramBus.ce = ce;

  // transmit bit is a level of the completion fifo, not a sticky flag
  assign intStat = {intDrain_ff, !cplEmpty, intAlloc_ff};

  // sticky flags cleared by writing one; a new event wins over the clear
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      intAlloc_ff <= 1'b0;
      intDrain_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (wrEn && (awAddr_ff == ADR_INTSTAT))
      begin
        if (wData_ff[INT_ALLOC])
          intAlloc_ff <= 1'b0;
        if (wData_ff[INT_DRAIN])
          intDrain_ff <= 1'b0;
      end
      if (allocOk)
        intAlloc_ff <= 1'b1;
      if (autoFree && (txCount == (PKT_W + 1)'(1)) && !txPush)
        intDrain_ff <= 1'b1;
      irq_ff <= |(intStat & intMask_ff);
    end
  end
  assign irq = irq_ff;

  // register read multiplexer
  always_comb
  begin
    rdMux = 32'h0;
    case (arAddr_ff)
      ADR_CTRL: rdMux = {29'h0, ctrl_ff};
      ADR_ALLOC: rdMux = {24'h0, !allocValid_ff, 4'h0, allocRes_ff};
      ADR_PKTNUM: rdMux = {29'h0, pktNum_ff};
      ADR_PTR: rdMux = {26'h0, ptr_ff};
      ADR_DATA: rdMux = ramBus.rdata;
      ADR_INTSTAT: rdMux = {29'h0, intStat};
      ADR_INTMASK: rdMux = {29'h0, intMask_ff};
      ADR_PORTS: rdMux = {16'h0, tx_queue_drained_flag, 4'h0, failFlag_ff ? failPkt_ff : macTxPkt,
                          cplEmpty, 4'h0, cplq_ff[cplRd_ff[PKT_W-1:0]]};
      ADR_TXSTAT: rdMux = txStat_ff;
      default: rdMux = 32'h0;
    endcase
  end

  assign s_axi_arready = (rdState_ff == RD_IDLE);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rvalid = rvalid_ff;

  // read sequencer: one cycle for the ram, one to register the answer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdState_ff <= RD_IDLE;
      arAddr_ff <= '0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
    end
    else if (ce)
    begin
      unique case (rdState_ff)
        RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            arAddr_ff <= s_axi_araddr;
            rdState_ff <= RD_MEM;
          end
        end
        RD_MEM:
        begin
          if (!ramBus.we)
            rdState_ff <= RD_GRAB;
        end
        RD_GRAB:
        begin
          rdata_ff <= rdMux;
          rresp_ff <= regHit(arAddr_ff) ? RESP_OKAY : RESP_SLVERR;
          rvalid_ff <= 1'b1;
          rdState_ff <= RD_RESP;
        end
        RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rvalid_ff <= 1'b0;
            rdState_ff <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // checks on the queue manager behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst || !ce);

  sequence sDone;
    macDone && inFlight_ff;
  endsequence
  sequence sFail;
    sDone ##0 !macOk;
  endsequence

  AST_ALLOC_DONE: assert property (allocOk |=> intAlloc_ff && allocValid_ff)
    else $error("allocation grant did not post flag and result");
  AST_ALLOC_HOLD: assert property ((allocPend_ff && !allocOk && !allocValid_ff)
    |=> !allocValid_ff)
    else $error("result valid without a granted allocation");
  AST_ENQ: assert property (txPush |=> txq_ff[$past(txWrIdx)] == $past(pktNum_ff))
    else $error("enqueue did not store the packet number");
  AST_TXEN_GATE: assert property (macTxValid |-> ctrl_ff[CTRL_TXEN]
    && !(ctrl_ff[CTRL_HALF] && macDeferBusy))
    else $error("hand-off offered while disabled or deferring");
  AST_STATUS_WR: assert property (sDone |-> ramBus.we
    && ramBus.addr == {flightPkt_ff, {WORD_W{1'b0}}} && ramBus.wdata == macStatus)
    else $error("status word not written to word zero");
  AST_CPL_MOVE: assert property ((sDone ##0 !autoFree && !cplFull && !cplPop)
    |=> cplCount == $past(cplCount) + 1'b1)
    else $error("completed packet not moved to completion fifo");
  AST_TX_IRQ: assert property ((!cplEmpty && intMask_ff[INT_TX]) |=> irq)
    else $error("transmit interrupt missing");
  AST_FAIL_STOP: assert property (sFail |=> !ctrl_ff[CTRL_TXEN] ##0 !macTxValid)
    else $error("failure did not halt the queue");
  AST_FAIL_PORT: assert property (sFail |=> failFlag_ff
    && failPkt_ff == $past(flightPkt_ff))
    else $error("failed packet number not presented");
  AST_RELEASE: assert property ((relGo && !allocOk) |=> !used_ff[$past(pktNum_ff)])
    else $error("release did not free the slot");
  AST_ACK_POP: assert property ((cplPop && !cplPush)
    |=> cplCount == $past(cplCount) - 1'b1)
    else $error("acknowledge did not pop the completion fifo");
  AST_AUTO_FREE: assert property ((autoFree && !allocOk) |=> !used_ff[$past(flightPkt_ff)]
    && cplCount == $past(cplCount) - (PKT_W + 1)'($past(cplPop)))
    else $error("auto release did not free the slot");
  AST_RD_LAT: assert property ((s_axi_arvalid && s_axi_arready) |-> ##[2:8] s_axi_rvalid)
    else $error("read answer late");
endmodule : txqm_core

// ===== sim/txqm_mac_model.sv
// txqm_mac_model: behavioural mac transmit engine facing the core
// assumes the core clock; the bench sets lag, fault and deferral
`timescale 1ns/10ps
module txqm_mac_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench controls
  input wire logic [3:0] lag,
  input wire logic failNext,
  input wire logic deferOn,
  // hand-off from the core
  input wire logic macTxValid,
  input wire logic [txqm_pkg::PKT_W-1:0] macTxPkt,
  output logic macTxReady,
  output logic macDeferBusy,
  output logic macDone,
  output logic macOk,
  output logic [31:0] macStatus
);
  logic busy_ff;
  logic [2:0] pkt_ff;
  logic [3:0] cnt_ff;
  // one frame on the wire at a time
  assign macTxReady = !busy_ff;
  assign macDeferBusy = deferOn;
  // frame timer; status lines toggle outside the done cycle so stale data shows
  always_ff @(posedge clock)
  begin
    macDone <= 1'b0;
    macOk <= ~macOk;
    macStatus <= ~macStatus;
    if (rst)
    begin
      busy_ff <= 1'b0;
      macOk <= 1'b0;
      macStatus <= 32'h0;
    end
    else if (macTxValid && macTxReady)
    begin
      busy_ff <= 1'b1;
      pkt_ff <= macTxPkt;
      cnt_ff <= lag;
    end
    else if (busy_ff && cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
    else if (busy_ff)
    begin
      busy_ff <= 1'b0;
      macDone <= 1'b1;
      macOk <= !failNext;
      macStatus <= {16'h5a00, 7'h0, !failNext, 5'h0, pkt_ff};
    end
  end
endmodule : txqm_mac_model

// ===== sim/tx_packet_queue_manager_tb_top.sv
// tx_packet_queue_manager_tb_top: register level tests of the queue manager
// assumes the mac model answers every hand-off; bench acts as host
`timescale 1ns/10ps
module tx_packet_queue_manager_tb_top;
  import txqm_pkg::*;
  logic clock, rst, ce, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, macStatus, rdat;
  logic [3:0] s_axi_wstrb, lag;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, macTxValid, macTxReady;
  logic macDeferBusy, macDone, macOk, failNext, deferOn;
  logic [2:0] macTxPkt, p0, p1, p2, q;
  int err_count, samples_checked;
  txqm_core uut (.clock, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .macTxValid,
    .macTxPkt, .macTxReady, .macDeferBusy, .macDone, .macOk, .macStatus, .irq);
  txqm_mac_model mac (.clock, .rst, .lag, .failNext, .deferOn, .macTxValid,
    .macTxPkt, .macTxReady, .macDeferBusy, .macDone, .macOk, .macStatus);
  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // handshakes judged mid-cycle, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awT, wT, bT;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever
    begin
      @(negedge clock);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bT = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clock);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
      if (bT) break;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic arT, rT;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever
    begin
      @(negedge clock);
      arT = s_axi_arvalid && s_axi_arready;
      rT = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clock);
      if (arT) s_axi_arvalid <= 1'b0;
      if (rT && !arT) break;
    end
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask : rc
  function automatic logic [31:0] st(input logic ok, input logic [2:0] p);
    return {16'h5a00, 7'h0, ok, 5'h0, p};
  endfunction : st
  task automatic alloc(output logic [2:0] p);
    wr(ADR_CMD, {16'd100, 12'h0, CMD_ALLOC});
    rd(ADR_ALLOC);
    chk(rdat & 32'h80, 32'h0);
    p = rdat[2:0];
    rc(ADR_INTSTAT, 32'h1, 32'h1);
    wr(ADR_INTSTAT, 32'h1);
  endtask : alloc
  // wait until the transmit fifo has drained
  task automatic drain();
    for (int i = 0; i < 60; i++)
    begin
      rd(ADR_PORTS);
      if (rdat[15] === 1'b1) break;
    end
  endtask : drain
  // ts: status of the last packet finished, which need not be p
  task automatic serve(input logic [2:0] p, input logic ok, input logic [31:0] ts);
    rc(ADR_PORTS, 32'h87, {29'h0, p});
    rc(ADR_TXSTAT, 32'hffffffff, ts);
    wr(ADR_PKTNUM, {29'h0, p});
    wr(ADR_PTR, 32'h0);
    rc(ADR_DATA, 32'hffffffff, st(ok, p));
    if (ok) wr(ADR_CMD, {28'h0, CMD_RELEASE});
    wr(ADR_TXACK, 32'h1);
  endtask : serve
  // a hang counts as a mismatch
  initial
  begin
    repeat (30000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, failNext, deferOn} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lag} = 52'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_bready, s_axi_rready, ce, rst} = 4'hf;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // reset values and an unmapped place
    rc(ADR_CTRL, 32'hffffffff, 32'h0);
    rc(ADR_INTMASK, 32'hffffffff, 32'h0);
    rd(8'h40);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h42, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    // allocation, pending request and masked flag
    alloc(p0);
    alloc(p1);
    alloc(p2);
    chk({31'h0, p0 == p1 || p1 == p2}, 32'h0);
    wr(ADR_CMD, {16'd300, 12'h0, CMD_ALLOC});
    rc(ADR_ALLOC, 32'h80, 32'h80);
    rc(ADR_INTSTAT, 32'h1, 32'h0);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test alloc done");
    // load, then hold the queue while tx enable is clear
    wr(ADR_PKTNUM, {29'h0, p0});
    wr(ADR_PTR, 32'h0);
    wr(ADR_DATA, 32'h11111111);
    wr(ADR_DATA, 32'h22222222);
    wr(ADR_PTR, 32'h1);
    rc(ADR_DATA, 32'hffffffff, 32'h22222222);
    wr(ADR_INTMASK, 32'h2);
    wr(ADR_CMD, {28'h0, CMD_ENQUEUE});
    wr(ADR_PKTNUM, {29'h0, p1});
    wr(ADR_CMD, {28'h0, CMD_ENQUEUE});
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk({31'h0, macTxValid}, 32'h0);
    rc(ADR_PORTS, 32'h8700, {21'h0, p0, 8'h0});
    wr(ADR_CTRL, 32'h1);
    drain();
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    serve(p0, 1'b1, st(1'b1, p1));
    serve(p1, 1'b1, st(1'b1, p1));
    rc(ADR_INTSTAT, 32'h2, 32'h0);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test queue done");
    // deferral, slow failure and retry
    lag <= 4'h6;
    deferOn <= 1'b1;
    wr(ADR_CTRL, 32'h5);
    wr(ADR_PKTNUM, {29'h0, p2});
    wr(ADR_CMD, {28'h0, CMD_ENQUEUE});
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk({31'h0, macTxValid}, 32'h0);
    @(posedge clock);
    failNext <= 1'b1;
    deferOn <= 1'b0;
    drain();
    rc(ADR_CTRL, 32'h1, 32'h0);
    rc(ADR_PORTS, 32'h700, {21'h0, p2, 8'h0});
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    serve(p2, 1'b0, st(1'b0, p2));
    failNext <= 1'b0;
    wr(ADR_PKTNUM, {29'h0, p2});
    wr(ADR_CTRL, 32'h1);
    wr(ADR_CMD, {28'h0, CMD_ENQUEUE});
    drain();
    serve(p2, 1'b1, st(1'b1, p2));
    $display("test failure done");
    // fill every slot, then a release grants the waiting request
    for (int i = 0; i < 8; i++) alloc(q);
    wr(ADR_INTMASK, 32'h1);
    wr(ADR_CMD, {16'd100, 12'h0, CMD_ALLOC});
    rc(ADR_ALLOC, 32'h80, 32'h80);
    wr(ADR_PKTNUM, {29'h0, q});
    wr(ADR_CMD, {28'h0, CMD_RELEASE});
    rc(ADR_ALLOC, 32'h87, {29'h0, q});
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(ADR_INTSTAT, 32'h1);
    rc(ADR_INTSTAT, 32'h1, 32'h0);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test release done");
    // auto release: the slot frees itself, no completion entry, drained flag set
    wr(ADR_CTRL, 32'h3);
    wr(ADR_CMD, {28'h0, CMD_ENQUEUE});
    drain();
    rc(ADR_INTSTAT, 32'h6, 32'h4);
    alloc(p0);
    chk({29'h0, p0}, {29'h0, q});
    $display("test auto done");
    print_verdict();
  end
endmodule : tx_packet_queue_manager_tb_top
